// File: rtl/apdu_pkg.sv
// shared codes, status words and sizes for the command interpreter
package apdu_pkg;
  // instruction codes
  localparam logic [7:0] INS_SELECT   = 8'hA4,
                         INS_STATUS   = 8'hF2,
                         INS_RD_BIN   = 8'hB0,
                         INS_UPD_BIN  = 8'hD6,
                         INS_RD_REC   = 8'hB2,
                         INS_UPD_REC  = 8'hDC,
                         INS_SEARCH   = 8'hA2,
                         INS_INCREASE = 8'h32,
                         INS_RETRIEVE = 8'hCB,
                         INS_SET_DATA = 8'hDB,
                         INS_VERIFY   = 8'h20,
                         INS_CHG_PIN  = 8'h24,
                         INS_DIS_PIN  = 8'h26,
                         INS_ENA_PIN  = 8'h28,
                         INS_UNBLOCK  = 8'h2C,
                         INS_DEACT    = 8'h04,
                         INS_ACT      = 8'h44,
                         INS_AUTH_A   = 8'h88,
                         INS_AUTH_B   = 8'h89,
                         INS_CHAL     = 8'h84,
                         INS_TPROF    = 8'h10,
                         INS_ENVELOPE = 8'hC2,
                         INS_FETCH    = 8'h12,
                         INS_TRSP     = 8'h14,
                         INS_CHANNEL  = 8'h70,
                         INS_GET_RSP  = 8'hC0;
  // class byte, unused byte, Le limit and sizes
  localparam logic [7:0] CLA_TOOLKIT = 8'h80;
  localparam logic [3:0] CLS_0X      = 4'h0,
                         CLS_8X      = 4'h8,
                         CLS_AX      = 4'hA;
  localparam logic [7:0] BYTE_UNUSED = 8'h00;
  localparam logic [8:0] LE_MAX      = 9'h100;
  localparam int         HDR_BYTES   = 4;
  localparam int         FIFO_DEPTH  = 8;
  // status bytes
  localparam logic [7:0] SW1_NORMAL  = 8'h90,
                         SW1_PEND    = 8'h91,
                         SW1_BUSY    = 8'h93,
                         SW1_WARN    = 8'h62,
                         SW1_WARN_X  = 8'h63,
                         SW1_EXEC_NC = 8'h64,
                         SW1_EXEC_CH = 8'h65,
                         SW1_BAD_INS = 8'h6D;
  localparam logic [7:0] SW2_NONE    = 8'h00,
                         SW2_CORRUPT = 8'h81,
                         SW2_EOF     = 8'h82,
                         SW2_INVAL   = 8'h83,
                         SW2_TERM    = 8'h85,
                         SW2_MORE    = 8'hF1,
                         SW2_MORE_PD = 8'hF2,
                         SW2_AUTH    = 8'hF3,
                         SW2_MEM     = 8'h81;
  localparam logic [3:0] SW2_RETRY_HI = 4'hC;
  typedef enum logic [4:0] {
    ST_OK, ST_PEND, ST_BUSY, ST_WARN, ST_CORRUPT, ST_EOF, ST_INVAL, ST_TERM,
    ST_MORE, ST_MORE_PEND, ST_AUTH, ST_EXPECT, ST_EXPECT_PEND, ST_RETRY,
    ST_NV_SAME, ST_NV_CHANGED, ST_MEMORY
  } status_t;
endpackage

// File: rtl/apdu_link_if.sv
// byte link between terminal and card
`timescale 1ns/100ps
`default_nettype none
interface apdu_link_if;
  logic       cmd_valid;
  logic       cmd_ready;
  logic [7:0] cmd_data;
  logic       rsp_valid;
  logic       rsp_ready;
  logic       rsp_last;
  logic [7:0] rsp_data;
  modport card (input cmd_valid, input cmd_data, input rsp_ready,
                output cmd_ready, output rsp_valid, output rsp_data, output rsp_last);
  modport term (output cmd_valid, output cmd_data, output rsp_ready,
                input cmd_ready, input rsp_valid, input rsp_data, input rsp_last);
endinterface
`default_nettype wire

// File: rtl/byte_fifo.sv
// synchronous fifo with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != CW'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + CW'(push) - CW'(pop);
    end
  end
endmodule
`default_nettype wire

// File: rtl/apdu_card.sv
// card end: command header decode, body handling and status encoding
// Overview of operation
// - recognise documented instruction codes
// - toolkit commands need class exactly 80
// - terminal sends unused P1/P2 as 00
// - Lc gives count of following data bytes
// - terminal data field is 1 to 255
// - terminal omits Le when expecting nothing; this terminal always sends a fifth length byte, req_len
// - Le of 00 means up to 256
// - with Le 00 return 1 to 256; the card returns no data when app_lr is 0
// - response is data then SW1, SW2
// - normal ending gives 90 00
// - pending proactive gives 91 and length
// - toolkit busy gives 93 00
// - plain warning gives 62 00
// - 62 with 81, 82, 83, 85 warnings
// - 62 with F1, F2, F3 warnings
// - 63 F1 and 63 F2 more expected
// - 63 CX gives retry count
// - on PIN verify CX gives attempts left
// - execution errors 64 00, 65 00, 65 81
// - class low two bits select channel
// - class upper nibble gives command family
// - unknown instruction answers 6D 00
`timescale 1ns/100ps
`default_nettype none
module apdu_card #(
  parameter int FIFO_DEPTH = apdu_pkg::FIFO_DEPTH
) (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  apdu_link_if.card              link,
  output logic                   cmd_start,
  output logic [7:0]             cmd_cla,
  output logic [7:0]             cmd_ins,
  output logic [7:0]             cmd_p1,
  output logic [7:0]             cmd_p2,
  output logic [1:0]             cmd_chan,
  output logic [1:0]             cmd_family,
  output logic                   cmd_outgoing,
  output logic [8:0]             cmd_len,
  output logic                   dat_valid,
  output logic [7:0]             dat_byte,
  input  wire logic              app_done,
  input  wire apdu_pkg::status_t app_status,
  input  wire logic [7:0]        app_arg,
  input  wire logic [8:0]        app_lr,
  input  wire logic              app_rsp_valid,
  input  wire logic [7:0]        app_rsp_data,
  output logic                   app_rsp_ready,
  output logic                   idle
);
  typedef enum logic [6:0] {
    S_HDR   = 7'b0000001,
    S_LEN   = 7'b0000010,
    S_DATA  = 7'b0000100,
    S_EXEC  = 7'b0001000,
    S_RDATA = 7'b0010000,
    S_SW1   = 7'b0100000,
    S_SW2   = 7'b1000000
  } state_t;

  state_t      state_reg;
  logic [7:0]  hdr_reg [apdu_pkg::HDR_BYTES];
  logic [1:0]  hdr_cnt_reg;
  logic [8:0]  left_reg;
  logic [8:0]  le_reg;
  logic [7:0]  sw1_reg;
  logic [7:0]  sw2_reg;
  logic        fifo_valid;
  logic [7:0]  fifo_data;
  logic        take;
  logic        pop;
  logic [1:0]  dec;
  logic        slot_free;
  logic        rsp_take;

  // family-checked decode: {known, sends response data}
  function automatic logic [1:0] ins_decode(input logic [7:0] cla, input logic [7:0] ins);
    logic f0;
    logic f8;
    logic ft;
    f0 = (cla[7:4] == apdu_pkg::CLS_0X) || (cla[7:4] == apdu_pkg::CLS_AX);
    f8 = (cla[7:4] == apdu_pkg::CLS_8X);
    ft = (cla == apdu_pkg::CLA_TOOLKIT);
    case (ins)
      apdu_pkg::INS_SELECT, apdu_pkg::INS_UPD_BIN, apdu_pkg::INS_UPD_REC,
      apdu_pkg::INS_SEARCH, apdu_pkg::INS_VERIFY, apdu_pkg::INS_CHG_PIN,
      apdu_pkg::INS_DIS_PIN, apdu_pkg::INS_ENA_PIN, apdu_pkg::INS_UNBLOCK,
      apdu_pkg::INS_DEACT, apdu_pkg::INS_ACT, apdu_pkg::INS_AUTH_A,
      apdu_pkg::INS_AUTH_B, apdu_pkg::INS_CHANNEL: return {f0, 1'b0};
      apdu_pkg::INS_RD_BIN, apdu_pkg::INS_RD_REC, apdu_pkg::INS_CHAL,
      apdu_pkg::INS_GET_RSP: return {f0, 1'b1};
      apdu_pkg::INS_STATUS, apdu_pkg::INS_RETRIEVE: return {f8, 1'b1};
      apdu_pkg::INS_INCREASE, apdu_pkg::INS_SET_DATA: return {f8, 1'b0};
      apdu_pkg::INS_FETCH: return {ft, 1'b1};
      apdu_pkg::INS_TPROF, apdu_pkg::INS_ENVELOPE, apdu_pkg::INS_TRSP: return {ft, 1'b0};
      default: return 2'b00;
    endcase
  endfunction

  function automatic logic [15:0] sw_encode(input apdu_pkg::status_t st, input logic [7:0] arg);
    case (st)
      apdu_pkg::ST_OK:          return {apdu_pkg::SW1_NORMAL, apdu_pkg::SW2_NONE};
      apdu_pkg::ST_PEND:        return {apdu_pkg::SW1_PEND, arg};
      apdu_pkg::ST_BUSY:        return {apdu_pkg::SW1_BUSY, apdu_pkg::SW2_NONE};
      apdu_pkg::ST_WARN:        return {apdu_pkg::SW1_WARN, apdu_pkg::SW2_NONE};
      apdu_pkg::ST_CORRUPT:     return {apdu_pkg::SW1_WARN, apdu_pkg::SW2_CORRUPT};
      apdu_pkg::ST_EOF:         return {apdu_pkg::SW1_WARN, apdu_pkg::SW2_EOF};
      apdu_pkg::ST_INVAL:       return {apdu_pkg::SW1_WARN, apdu_pkg::SW2_INVAL};
      apdu_pkg::ST_TERM:        return {apdu_pkg::SW1_WARN, apdu_pkg::SW2_TERM};
      apdu_pkg::ST_MORE:        return {apdu_pkg::SW1_WARN, apdu_pkg::SW2_MORE};
      apdu_pkg::ST_MORE_PEND:   return {apdu_pkg::SW1_WARN, apdu_pkg::SW2_MORE_PD};
      apdu_pkg::ST_AUTH:        return {apdu_pkg::SW1_WARN, apdu_pkg::SW2_AUTH};
      apdu_pkg::ST_EXPECT:      return {apdu_pkg::SW1_WARN_X, apdu_pkg::SW2_MORE};
      apdu_pkg::ST_EXPECT_PEND: return {apdu_pkg::SW1_WARN_X, apdu_pkg::SW2_MORE_PD};
      // retries done, or attempts left after a failed PIN check
      apdu_pkg::ST_RETRY:       return {apdu_pkg::SW1_WARN_X, apdu_pkg::SW2_RETRY_HI, arg[3:0]};
      apdu_pkg::ST_NV_SAME:     return {apdu_pkg::SW1_EXEC_NC, apdu_pkg::SW2_NONE};
      apdu_pkg::ST_NV_CHANGED:  return {apdu_pkg::SW1_EXEC_CH, apdu_pkg::SW2_NONE};
      apdu_pkg::ST_MEMORY:      return {apdu_pkg::SW1_EXEC_CH, apdu_pkg::SW2_MEM};
      default:                  return {apdu_pkg::SW1_NORMAL, apdu_pkg::SW2_NONE};
    endcase
  endfunction

  // command bytes are buffered; the interpreter stalls them while executing
  assign take = (state_reg == S_HDR) || (state_reg == S_LEN) || (state_reg == S_DATA);
  assign pop  = take && fifo_valid;
  assign dec  = ins_decode(hdr_reg[0], hdr_reg[1]);
  assign slot_free = !link.rsp_valid || link.rsp_ready;
  assign rsp_take  = app_rsp_ready && app_rsp_valid;

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_cmd_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (link.cmd_valid),
    .in_data   (link.cmd_data),
    .in_ready  (link.cmd_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (take)
  );

  // sequencing
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg   <= S_HDR;
      hdr_cnt_reg <= '0;
      left_reg    <= '0;
      le_reg      <= '0;
      sw1_reg     <= '0;
      sw2_reg     <= '0;
    end else begin
      case (state_reg)
        S_HDR: begin
          if (pop) begin
            hdr_cnt_reg <= hdr_cnt_reg + 2'd1;
            if (hdr_cnt_reg == 2'(apdu_pkg::HDR_BYTES - 1)) begin
              state_reg <= S_LEN;
            end
          end
        end
        S_LEN: begin
          if (pop) begin
            if (!dec[1]) begin
              {sw1_reg, sw2_reg} <= {apdu_pkg::SW1_BAD_INS, apdu_pkg::SW2_NONE};
              left_reg  <= '0;
              state_reg <= S_SW1;
            end else if (dec[0]) begin
              le_reg    <= (fifo_data == apdu_pkg::BYTE_UNUSED) ? apdu_pkg::LE_MAX
                           : {1'b0, fifo_data};
              state_reg <= S_EXEC;
            end else if (fifo_data != apdu_pkg::BYTE_UNUSED) begin
              left_reg  <= {1'b0, fifo_data};
              state_reg <= S_DATA;
            end else begin
              state_reg <= S_EXEC;
            end
          end
        end
        S_DATA: begin
          if (pop) begin
            left_reg <= left_reg - 9'd1;
            if (left_reg == 9'd1) begin
              state_reg <= S_EXEC;
            end
          end
        end
        S_EXEC: begin
          if (app_done) begin
            {sw1_reg, sw2_reg} <= sw_encode(app_status, app_arg);
            // data only on outgoing commands, never past Le
            left_reg  <= !cmd_outgoing ? 9'd0 : (app_lr > le_reg) ? le_reg : app_lr;
            state_reg <= (cmd_outgoing && app_lr != 9'd0) ? S_RDATA : S_SW1;
          end
        end
        S_RDATA: begin
          if (rsp_take) begin
            left_reg <= left_reg - 9'd1;
            if (left_reg == 9'd1) begin
              state_reg <= S_SW1;
            end
          end
        end
        S_SW1: begin
          if (slot_free) begin
            state_reg <= S_SW2;
          end
        end
        S_SW2: begin
          if (slot_free) begin
            hdr_cnt_reg <= '0;
            state_reg   <= S_HDR;
          end
        end
        default: state_reg <= S_HDR;
      endcase
    end
  end

  // header capture and decoded command outputs
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < apdu_pkg::HDR_BYTES; i++) begin
        hdr_reg[i] <= '0;
      end
      cmd_start    <= 1'b0;
      cmd_cla      <= '0;
      cmd_ins      <= '0;
      cmd_p1       <= '0;
      cmd_p2       <= '0;
      cmd_chan     <= '0;
      cmd_family   <= '0;
      cmd_outgoing <= 1'b0;
      cmd_len      <= '0;
    end else begin
      cmd_start <= 1'b0;
      if (state_reg == S_HDR && pop) begin
        hdr_reg[hdr_cnt_reg] <= fifo_data;
      end
      if (state_reg == S_LEN && pop && dec[1]) begin
        cmd_start    <= 1'b1;
        cmd_cla      <= hdr_reg[0];
        cmd_ins      <= hdr_reg[1];
        cmd_p1       <= hdr_reg[2];
        cmd_p2       <= hdr_reg[3];
        cmd_chan     <= hdr_reg[0][1:0];
        cmd_family   <= (hdr_reg[0][7:4] == apdu_pkg::CLS_8X) ? 2'd1 :
                        (hdr_reg[0][7:4] == apdu_pkg::CLS_AX) ? 2'd2 : 2'd0;
        cmd_outgoing <= dec[0];
        cmd_len      <= (dec[0] && fifo_data == apdu_pkg::BYTE_UNUSED) ? apdu_pkg::LE_MAX
                        : {1'b0, fifo_data};
      end
    end
  end

  // command data handed to the application
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dat_valid <= 1'b0;
      dat_byte  <= '0;
    end else begin
      dat_valid <= (state_reg == S_DATA) && pop;
      if ((state_reg == S_DATA) && pop) begin
        dat_byte <= fifo_data;
      end
    end
  end

  // response pull: ready is offered only while the output slot is empty
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      app_rsp_ready <= 1'b0;
    end else begin
      app_rsp_ready <= (state_reg == S_RDATA) && !rsp_take && !link.rsp_valid
                       && (left_reg != 9'd0);
    end
  end

  // response byte slot toward the terminal
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      link.rsp_valid <= 1'b0;
      link.rsp_data  <= '0;
      link.rsp_last  <= 1'b0;
    end else begin
      if (link.rsp_valid && link.rsp_ready) begin
        link.rsp_valid <= 1'b0;
        link.rsp_last  <= 1'b0;
      end
      if (rsp_take) begin
        link.rsp_valid <= 1'b1;
        link.rsp_data  <= app_rsp_data;
      end else if (state_reg == S_SW1 && slot_free) begin
        link.rsp_valid <= 1'b1;
        link.rsp_data  <= sw1_reg;
      end else if (state_reg == S_SW2 && slot_free) begin
        link.rsp_valid <= 1'b1;
        link.rsp_data  <= sw2_reg;
        link.rsp_last  <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      idle <= 1'b1;
    end else begin
      idle <= (state_reg == S_HDR) && (hdr_cnt_reg == 2'd0) && !pop;
    end
  end
endmodule
`default_nettype wire

// File: rtl/apdu_terminal.sv
// terminal end: sends command header, length and data, collects response
`timescale 1ns/100ps
`default_nettype none
module apdu_terminal (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  apdu_link_if.term       link,
  input  wire logic       req_valid,
  output logic            req_ready,
  input  wire logic [7:0] req_cla,
  input  wire logic [7:0] req_ins,
  input  wire logic [7:0] req_p1,
  input  wire logic       req_use_p1,
  input  wire logic [7:0] req_p2,
  input  wire logic       req_use_p2,
  input  wire logic [7:0] req_len,
  input  wire logic       req_has_data,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            done,
  output logic [7:0]      sw1,
  output logic [7:0]      sw2
);
  typedef enum logic [3:0] {
    T_IDLE = 4'b0001,
    T_HDR  = 4'b0010,
    T_DATA = 4'b0100,
    T_WAIT = 4'b1000
  } tstate_t;

  tstate_t    state_reg;
  logic [7:0] hdr_reg [5];
  logic [2:0] idx_reg;
  logic [7:0] left_reg;
  logic [7:0] prev_reg;
  logic       accept;
  logic       slot_free;
  logic       tx_take;
  logic       rx_take;
  logic       toolkit;

  assign accept    = req_ready && req_valid;
  assign slot_free = !link.cmd_valid || link.cmd_ready;
  assign tx_take   = tx_ready && tx_valid;
  assign rx_take   = link.rsp_valid && link.rsp_ready;
  assign toolkit   = (req_ins == apdu_pkg::INS_TPROF) || (req_ins == apdu_pkg::INS_ENVELOPE)
                     || (req_ins == apdu_pkg::INS_FETCH) || (req_ins == apdu_pkg::INS_TRSP);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg <= T_IDLE;
      idx_reg   <= '0;
      left_reg  <= '0;
      for (int i = 0; i < 5; i++) begin
        hdr_reg[i] <= '0;
      end
    end else begin
      case (state_reg)
        T_IDLE: begin
          if (accept) begin
            hdr_reg[0] <= toolkit ? apdu_pkg::CLA_TOOLKIT : req_cla;
            hdr_reg[1] <= req_ins;
            hdr_reg[2] <= req_use_p1 ? req_p1 : apdu_pkg::BYTE_UNUSED;
            hdr_reg[3] <= req_use_p2 ? req_p2 : apdu_pkg::BYTE_UNUSED;
            // the length byte goes out as req_len; req_has_data only decides whether data follows
            hdr_reg[4] <= req_len;
            left_reg   <= req_has_data ? req_len : 8'd0;
            idx_reg    <= '0;
            state_reg  <= T_HDR;
          end
        end
        T_HDR: begin
          if (slot_free) begin
            idx_reg <= idx_reg + 3'd1;
            if (idx_reg == 3'd4) begin
              state_reg <= (left_reg != 8'd0) ? T_DATA : T_WAIT;
            end
          end
        end
        T_DATA: begin
          if (tx_take) begin
            left_reg <= left_reg - 8'd1;
            if (left_reg == 8'd1) begin
              state_reg <= T_WAIT;
            end
          end
        end
        T_WAIT: begin
          if (rx_take && link.rsp_last) begin
            state_reg <= T_IDLE;
          end
        end
        default: state_reg <= T_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      link.cmd_valid <= 1'b0;
      link.cmd_data  <= '0;
      tx_ready       <= 1'b0;
      req_ready      <= 1'b0;
    end else begin
      if (link.cmd_valid && link.cmd_ready) begin
        link.cmd_valid <= 1'b0;
      end
      if (state_reg == T_HDR && slot_free) begin
        link.cmd_valid <= 1'b1;
        link.cmd_data  <= hdr_reg[idx_reg];
      end else if (tx_take) begin
        link.cmd_valid <= 1'b1;
        link.cmd_data  <= tx_data;
      end
      tx_ready  <= (state_reg == T_DATA) && !tx_take && !link.cmd_valid && (left_reg != 8'd0);
      req_ready <= (state_reg == T_IDLE) && !accept;
    end
  end

  // response side: SW1 is the byte before the one flagged last
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      link.rsp_ready <= 1'b0;
      rx_valid       <= 1'b0;
      rx_data        <= '0;
      prev_reg       <= '0;
      done           <= 1'b0;
      sw1            <= '0;
      sw2            <= '0;
    end else begin
      link.rsp_ready <= 1'b1;
      rx_valid       <= rx_take;
      done           <= rx_take && link.rsp_last;
      if (rx_take) begin
        rx_data  <= link.rsp_data;
        prev_reg <= link.rsp_data;
        if (link.rsp_last) begin
          sw1 <= prev_reg;
          sw2 <= link.rsp_data;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/apdu_link_chk.sv
// assertions on the byte link between terminal and card
`timescale 1ns/100ps
`default_nettype none
module apdu_link_chk (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic [7:0] cmd_data,
  input wire logic       rsp_valid,
  input wire logic       rsp_ready,
  input wire logic       rsp_last,
  input wire logic [7:0] rsp_data
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [2:0] hdr_reg;
  logic [7:0] sw1_reg;
  wire        fin = rsp_valid && rsp_ready && rsp_last;
  // header and length bytes of the current command, saturating at five
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      hdr_reg <= 3'h0;
    else if (fin)
      hdr_reg <= 3'h0;
    else if (cmd_valid && cmd_ready && hdr_reg < 3'h5)
      hdr_reg <= hdr_reg + 3'h1;
  end
  always_ff @(posedge ref_clk)
    if (rsp_valid && rsp_ready)
      sw1_reg <= rsp_data;
  property p_hdr; rsp_valid |-> hdr_reg == 3'h5; endproperty
  a_hdr: assert property (p_hdr) else $error("early response");
  property p_pair; fin |-> $past(rsp_valid) && $past(rsp_ready) && !$past(rsp_last); endproperty
  a_pair: assert property (p_pair) else $error("status pair split");
  property p_once; fin |=> !rsp_valid [*2]; endproperty
  a_once: assert property (p_once) else $error("bytes after status");
  property p_zero; fin && sw1_reg inside {8'h90, 8'h93, 8'h64, 8'h6D} |-> rsp_data == 8'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("bad second byte");
  property p_warn; fin && sw1_reg == 8'h62 |->
    rsp_data inside {8'h00, 8'h81, 8'h82, 8'h83, 8'h85, 8'hF1, 8'hF2, 8'hF3}; endproperty
  a_warn: assert property (p_warn) else $error("bad warning");
  property p_more; fin && sw1_reg == 8'h63 |->
    rsp_data inside {8'hF1, 8'hF2} || rsp_data[7:4] == 4'hC; endproperty
  a_more: assert property (p_more) else $error("bad retry code");
  property p_exec; fin && sw1_reg == 8'h65 |-> rsp_data inside {8'h00, 8'h81}; endproperty
  a_exec: assert property (p_exec) else $error("bad execution error");
  property p_sw1; fin |->
    sw1_reg inside {8'h90, 8'h91, 8'h93, 8'h62, 8'h63, 8'h64, 8'h65, 8'h6D}; endproperty
  a_sw1: assert property (p_sw1) else $error("bad first status byte");
endmodule
`default_nettype wire

// File: tb/test_apdu_header_decode_status_encode.sv
// bench joining terminal and card ends with a queue model of the exchange
`timescale 1ns/100ps
`default_nettype none
module test_apdu_header_decode_status_encode;
  logic       ref_clk = 1'b0, reset = 1'b1, req_valid = 1'b0, tx_valid = 1'b0;
  logic       app_done = 1'b0, app_rsp_valid = 1'b0, has_data = 1'b0, cmd_outgoing;
  logic [7:0] cla, ins, p1, p2, len, tx_data = 8'h00, app_arg = 8'h00, app_rsp_data = 8'h00;
  logic [8:0] app_lr = 9'h000;
  logic       req_ready, tx_ready, rx_valid, done, cmd_start, dat_valid, app_rsp_ready, idle;
  logic [7:0] rx_data, sw1, sw2, dat_byte, cmd_cla, cmd_ins, cmd_p1, cmd_p2, q_tx[$], q_dat[$];
  logic [7:0] q_rsp[$], q_exp[$];
  logic [1:0] cmd_chan, cmd_family;
  logic [8:0] cmd_len;
  int         mismatches = 0, num_checks = 0, seed = 97, cycles = 0, k;
  apdu_pkg::status_t app_status = apdu_pkg::ST_OK;
  logic [15:0] swt [17] = '{16'h9000, 16'h9100, 16'h9300, 16'h6200, 16'h6281, 16'h6282,
    16'h6283, 16'h6285, 16'h62F1, 16'h62F2, 16'h62F3, 16'h63F1, 16'h63F2, 16'h63C0,
    16'h6400, 16'h6500, 16'h6581};
  always #5 ref_clk = ~ref_clk;
  apdu_link_if link ();
  apdu_card u_apdu_card (.ref_clk, .reset, .link(link.card), .cmd_start, .cmd_cla,
    .cmd_ins, .cmd_p1, .cmd_p2, .cmd_chan, .cmd_family, .cmd_outgoing, .cmd_len,
    .dat_valid, .dat_byte, .app_done, .app_status, .app_arg, .app_lr, .app_rsp_valid,
    .app_rsp_data, .app_rsp_ready, .idle);
  apdu_terminal u_apdu_terminal (.ref_clk, .reset, .link(link.term), .req_valid, .req_ready,
    .req_cla(cla), .req_ins(ins), .req_p1(p1), .req_use_p1(1'b1), .req_p2(p2),
    .req_use_p2(1'b0), .req_len(len), .req_has_data(has_data), .tx_valid, .tx_data,
    .tx_ready, .rx_valid, .rx_data, .done, .sw1, .sw2);
  apdu_link_chk u_apdu_link_chk (.ref_clk, .reset, .cmd_valid(link.cmd_valid),
    .cmd_ready(link.cmd_ready), .cmd_data(link.cmd_data), .rsp_valid(link.rsp_valid),
    .rsp_ready(link.rsp_ready), .rsp_last(link.rsp_last), .rsp_data(link.rsp_data));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // byte feeders and receivers, all inputs moved 1 ns after the edge
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
    if (tx_valid && tx_ready) void'(q_tx.pop_front());
    if (app_rsp_valid && app_rsp_ready) void'(q_rsp.pop_front());
    if (dat_valid) chk(16'(dat_byte), 16'(q_dat.pop_front()));
    if (rx_valid) chk(16'(rx_data), 16'(q_exp.pop_front()));
    #1;
    tx_valid = q_tx.size() > 0;
    tx_data = tx_valid ? q_tx[0] : 8'h00;
    app_rsp_valid = q_rsp.size() > 0;
    app_rsp_data = app_rsp_valid ? q_rsp[0] : 8'h00;
  end
  task automatic run(input logic [7:0] c, input logic [7:0] i, input logic [7:0] l,
                     input int s, input logic x, input logic [8:0] lr);
    logic        o;
    logic [15:0] w;
    int          n;
    o = i inside {8'hB0, 8'hB2, 8'h84, 8'hC0, 8'hF2, 8'hCB, 8'h12};
    app_arg = 8'($random(seed));
    w = x ? 16'h6D00 : swt[s];
    if (s == 1) w[7:0] = app_arg;
    if (s == 13) w[3:0] = app_arg[3:0];
    n = (o && !x) ? ((int'(lr) < (l == 0 ? 256 : l)) ? lr : (l == 0 ? 256 : l)) : 0;
    for (int j = 0; j < (o ? 0 : l); j++) begin
      q_tx.push_back(8'($random(seed)));
      q_dat.push_back(q_tx[j]);
    end
    for (int j = 0; j < n; j++) begin
      q_rsp.push_back(8'($random(seed)));
      q_exp.push_back(q_rsp[j]);
    end
    q_exp.push_back(w[15:8]);
    q_exp.push_back(w[7:0]);
    {cla, ins, len, p1, p2} = {c, i, l, 16'($random(seed))};
    has_data = !o && l != 8'h00;
    app_status = apdu_pkg::status_t'(s);
    app_lr = lr;
    req_valid = 1'b1;
    do @(posedge ref_clk); while (!req_ready);
    #1 req_valid = 1'b0;
    if (!x) begin
      while (!cmd_start) @(posedge ref_clk);
      chk({cmd_cla, cmd_ins}, {c, i});
      chk(16'({cmd_family, cmd_chan}), 16'({c[5], c[7] && !c[5], c[1:0]}));
      chk({cmd_p1, cmd_p2}, {p1, 8'h00});
      chk({cmd_outgoing, 6'h0, cmd_len}, {o, 6'h0, o && l == 0, l});
      while (q_dat.size() > 0) @(posedge ref_clk);
      #1 app_done = 1'b1;
      @(posedge ref_clk);
      #1 app_done = 1'b0;
    end
    while (!done) @(posedge ref_clk);
    chk({sw1, sw2}, w);
    @(posedge ref_clk);
    chk({idle, 15'(q_exp.size())}, 16'h8000);
    $display("test done ins %h status %h%h", i, sw1, sw2);
    #1;
  endtask
  initial begin
    {cla, ins, p1, p2, len} = '0;
    repeat (5) @(posedge ref_clk);
    #1 reset = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    run(8'h00, 8'hA4, 8'h03, 0, 1'b0, 9'h000);
    run(8'h81, 8'hF2, 8'h04, 0, 1'b0, 9'h002);
    run(8'h03, 8'hB0, 8'h00, 0, 1'b0, 9'h009);
    run(8'h80, 8'hC2, 8'h02, 1, 1'b0, 9'h000);
    run(8'h80, 8'h12, 8'h03, 2, 1'b0, 9'h003);
    run(8'h00, 8'h55, 8'h00, 0, 1'b1, 9'h000);
    run(8'h00, 8'hF2, 8'h00, 0, 1'b1, 9'h000);
    run(8'hA1, 8'hC0, 8'hFF, 13, 1'b0, 9'h1FF);
    run(8'h00, 8'hD6, 8'hFF, 0, 1'b0, 9'h000);
    for (k = 0; k < 17; k++)
      run(8'h00, 8'hD6, {5'h00, 3'($random(seed))} + 8'h01, k, 1'b0, 9'h000);
    summarize();
  end
endmodule
`default_nettype wire
